// ===== hdl/epw_core.sv
// Enhanced PWM output stage: auto-shutdown, restart, dead band, steering.
// Assumes the raw modulated waveform and timer ticks come from logic on clk;
// fault pin and comparator outputs are asynchronous and synchronised here.
`timescale 1ns/1ps
`default_nettype none
module epw_core
    import epw_pkg::*;
#(
    parameter bit THIRD_MODULE = 1'b0
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic pwm_raw,
    input wire logic period_tick_two,
    input wire logic period_tick_four,
    input wire logic period_tick_six,
    input wire logic sixteen_bit_timer_tick,
    input wire logic fault_input_pin_n,
    input wire logic comparator_one,
    input wire logic comparator_two,
    input wire logic comparator_three,
    input wire logic [2:0] comparator_sync_enable,
    input wire logic clock_fallback_active,
    input wire logic [3:0] port_out,
    input wire logic [3:0] port_oe,
    output logic [3:0] pin_out,
    output logic [3:0] pin_oe,
    output logic irq
);
    // ************************************************************
    // State.
    // ************************************************************
    typedef struct packed {
        logic [1:0] tsel;
        logic [7:0] asc;
        logic [7:0] pwc;
        logic [4:0] psc;
        logic [7:0] mode;
        logic [1:0] ists;
        logic [1:0] imsk;
        logic flt_s1;
        logic flt_s2;
        logic [2:0] cmp_s1;
        logic [2:0] cmp_s2;
        logic [2:0] cmp_held;
        logic [3:0] steer_act;
        logic shut_out;
        logic [6:0] dly_cnt;
        logic wave_d;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic [3:0] pin_out;
        logic [3:0] pin_oe;
        logic irq;
    } epw_state_t;

    epw_state_t s_reg;
    epw_state_t s_next;

    // R03: source decode
    function automatic logic shut_decode(input logic [2:0] src,
                                         input logic flt,
                                         input logic c1,
                                         input logic c2);
        logic comp;
        comp = (src[0] & c1) | (src[1] & c2);
        shut_decode = (src[2] & flt) | comp;
    endfunction

    logic acc;
    logic wr;
    logic wr_asc;
    logic mapped;
    logic [2:0] cmp_eff;
    logic c2_sel;
    logic cond;
    logic ptick;
    logic mode_ok;
    logic flag_clr;
    logic flag_set;
    logic flag_new;
    logic [31:0] rdata;

    always_comb begin
        s_next = s_reg;
        acc = psel & penable;
        wr = acc & pwrite & s_reg.pready;
        mapped = (paddr[1:0] == 2'h0) && (paddr[31:8] == 24'h0)
            && (paddr[7:0] <= OFS_IMSK);
        wr_asc = wr && mapped && (paddr[7:0] == OFS_ASC);
        // Synchronisers: the first stages feed only the second stages.
        s_next.flt_s1 = ~fault_input_pin_n;
        s_next.flt_s2 = s_reg.flt_s1;
        s_next.cmp_s1 = {comparator_three, comparator_two, comparator_one};
        s_next.cmp_s2 = s_reg.cmp_s1;
        // R06: timer-aligned comparators
        if (sixteen_bit_timer_tick) begin
            s_next.cmp_held = s_reg.cmp_s2;
        end
        cmp_eff = (comparator_sync_enable & s_reg.cmp_held)
            | (~comparator_sync_enable & s_reg.cmp_s2);
        // R07: comparator three swap
        c2_sel = THIRD_MODULE ? cmp_eff[2] : cmp_eff[1];
        cond = shut_decode(s_reg.asc[6:4], s_reg.flt_s2, cmp_eff[0], c2_sel);
        // R01: period timer selection
        case (s_reg.tsel)
            TSEL_TWO: ptick = period_tick_two;
            TSEL_FOUR: ptick = period_tick_four;
            TSEL_SIX: ptick = period_tick_six;
            default: ptick = 1'b0;
        endcase
        // R14: steering only in single-output PWM
        mode_ok = (s_reg.mode[3:2] == MODE_PWM)
            && (s_reg.mode[7:6] == CFG_SINGLE);

        // ********************************************************
        // APB register access.
        // ********************************************************
        case (paddr[7:0])
            OFS_TSEL: rdata = {30'h0, s_reg.tsel};
            OFS_ASC: rdata = {24'h0, s_reg.asc};
            OFS_PWC: rdata = {24'h0, s_reg.pwc};
            OFS_PSC: rdata = {27'h0, s_reg.psc};
            OFS_MODE: rdata = {24'h0, s_reg.mode};
            OFS_ISTS: rdata = {30'h0, s_reg.ists};
            OFS_IMSK: rdata = {30'h0, s_reg.imsk};
            default: rdata = 32'h0;
        endcase
        s_next.pready = acc & ~s_reg.pready;
        s_next.pslverr = acc & ~s_reg.pready & ~mapped;
        s_next.prdata = (acc && !pwrite && mapped) ? rdata : 32'h0;
        if (wr && mapped) begin
            case (paddr[7:0])
                OFS_TSEL: s_next.tsel = pwdata[1:0];
                OFS_ASC: s_next.asc[6:0] = pwdata[6:0];
                OFS_PWC: s_next.pwc = pwdata[7:0];
                OFS_PSC: s_next.psc[PSC_SYNC] = pwdata[PSC_SYNC];
                OFS_MODE: s_next.mode = pwdata[7:0];
                OFS_ISTS: s_next.ists = s_reg.ists & ~pwdata[1:0];
                OFS_IMSK: s_next.imsk = pwdata[1:0];
                default: s_next.tsel = s_reg.tsel;
            endcase
        end
        // R11: delay count held at zero
        if (clock_fallback_active) begin
            s_next.pwc[6:0] = 7'h00;
        end

        // ********************************************************
        // Shutdown flag: a live cause always wins over any clear.
        // ********************************************************
        // R08: automatic restart clear
        flag_clr = s_reg.pwc[PWC_RSEN] & ~cond;
        // R09: software clear path
        if (wr_asc && !pwdata[ASC_FLAG]) begin
            flag_clr = 1'b1;
        end
        flag_set = cond | (wr_asc & pwdata[ASC_FLAG]);
        // R02: sticky shutdown flag
        flag_new = flag_set | (s_reg.asc[ASC_FLAG] & ~flag_clr);
        s_next.asc[ASC_FLAG] = flag_new;
        if (flag_new && !s_reg.asc[ASC_FLAG]) begin
            s_next.ists[IRQ_SHUT] = 1'b1;
        end
        if (!flag_new && s_reg.asc[ASC_FLAG] && s_reg.pwc[PWC_RSEN]
            && !wr_asc) begin
            s_next.ists[IRQ_RESTART] = 1'b1;
        end
        // R16: resume only at period start
        if (flag_new) begin
            s_next.shut_out = 1'b1;
        end else if (ptick) begin
            s_next.shut_out = 1'b0;
        end

        // ********************************************************
        // Steering enables and dead band.
        // ********************************************************
        // R12: steering update point
        if (!s_reg.psc[PSC_SYNC] || ptick) begin
            s_next.steer_act = s_reg.psc[3:0];
        end
        if (wr && mapped && paddr[7:0] == OFS_PSC) begin
            s_next.psc[3:0] = pwdata[3:0];
        end
        // R10: active edge delay
        if (!pwm_raw) begin
            s_next.wave_d = 1'b0;
            s_next.dly_cnt = 7'h00;
        end else if (!s_reg.wave_d) begin
            if (s_reg.dly_cnt >= s_reg.pwc[6:0]) begin
                s_next.wave_d = 1'b1;
            end else begin
                s_next.dly_cnt = s_reg.dly_cnt + 7'h01;
            end
        end

        // ********************************************************
        // Pin drivers.
        // ********************************************************
        for (int i = 0; i < 4; i++) begin
            logic [1:0] sst;
            logic pol;
            sst = i[0] ? s_reg.asc[1:0] : s_reg.asc[3:2];
            // R15: pair polarity
            pol = i[0] ? s_reg.mode[0] : s_reg.mode[1];
            // R13: route waveform or port
            if (!(mode_ok && s_reg.steer_act[i])) begin
                s_next.pin_out[i] = port_out[i];
                s_next.pin_oe[i] = port_oe[i];
            end else if (s_reg.shut_out) begin
                // R04: a/c shutdown level
                // R05: b/d shutdown level
                s_next.pin_oe[i] = ~sst[1];
                s_next.pin_out[i] = ~sst[1] & sst[0];
            end else begin
                s_next.pin_oe[i] = 1'b1;
                s_next.pin_out[i] = s_reg.wave_d ^ pol;
            end
        end
        s_next.irq = |(s_reg.ists & s_reg.imsk);
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            s_reg <= '0;
            s_reg.psc <= PSC_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    assign prdata = s_reg.prdata;
    assign pready = s_reg.pready;
    assign pslverr = s_reg.pslverr;
    assign pin_out = s_reg.pin_out;
    assign pin_oe = s_reg.pin_oe;
    assign irq = s_reg.irq;

    // ************************************************************
    // Checks.
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    a_pready_single: assert property (pready |=> !pready)
        else $error("pready held for more than one cycle");
    a_flag_on_cause: assert property (cond |=> s_reg.asc[ASC_FLAG]) // R02
        else $error("shutdown cause did not set flag");
    a_manual_hold: assert property ( // R09
        s_reg.asc[ASC_FLAG] && !s_reg.pwc[PWC_RSEN] && !wr_asc
        |=> s_reg.asc[ASC_FLAG])
        else $error("flag cleared without software");
    a_auto_clear: assert property ( // R08
        s_reg.asc[ASC_FLAG] && s_reg.pwc[PWC_RSEN] && !cond && !wr_asc
        |=> !s_reg.asc[ASC_FLAG])
        else $error("auto restart failed to clear flag");
    a_shut_until_period: assert property ( // R16
        s_reg.shut_out && !ptick |=> s_reg.shut_out)
        else $error("outputs resumed outside period start");
    a_pin_shut_low: assert property ( // R04
        mode_ok && s_reg.steer_act[0] && s_reg.shut_out
        && s_reg.asc[3:2] == 2'h0 |=> pin_oe[0] && !pin_out[0])
        else $error("pin a not driven low in shutdown");
    a_pin_shut_tri: assert property ( // R05
        mode_ok && s_reg.steer_act[1] && s_reg.shut_out && s_reg.asc[1]
        |=> !pin_oe[1])
        else $error("pin b not released in shutdown");
    a_steer_sync_hold: assert property ( // R12
        s_reg.psc[PSC_SYNC] && !ptick |=> $stable(s_reg.steer_act))
        else $error("steering changed before period start");
    a_dead_band: assert property ( // R10
        $rose(s_reg.wave_d) |-> $past(s_reg.dly_cnt) >= $past(s_reg.pwc[6:0]))
        else $error("active edge came before delay count");
    a_cmp_sync: assert property ( // R06
        !sixteen_bit_timer_tick |=> $stable(s_reg.cmp_held))
        else $error("synchronised comparator moved without timer");
    a_irq_level: assert property (
        |(s_reg.ists & s_reg.imsk) |=> irq)
        else $error("interrupt not raised");
    a_irq_quiet: assert property (
        !(|(s_reg.ists & s_reg.imsk)) |=> !irq)
        else $error("interrupt raised with nothing pending");
    a_pslverr_pair: assert property (pslverr |-> pready)
        else $error("error response without ready");
    a_access_answer: assert property (acc && !pready |=> pready)
        else $error("access phase not answered");
    a_timer_reserved: assert property (s_reg.tsel == 2'h3 |-> !ptick) // R01
        else $error("reserved timer code produced a period tick");
    a_timer_four: assert property ( // R01
        s_reg.tsel == TSEL_FOUR |-> ptick == period_tick_four)
        else $error("timer four not used as time base");
    a_timer_six: assert property ( // R01
        s_reg.tsel == TSEL_SIX |-> ptick == period_tick_six)
        else $error("timer six not used as time base");
    a_shut_on_flag: assert property ( // R02
        s_reg.asc[ASC_FLAG] |-> s_reg.shut_out)
        else $error("flag set while outputs run");
    a_shut_event: assert property ( // R02
        $rose(s_reg.asc[ASC_FLAG]) |-> s_reg.ists[IRQ_SHUT])
        else $error("shutdown event not recorded");
    a_source_off: assert property ( // R03
        s_reg.asc[6:4] == 3'h0 |-> !cond)
        else $error("disabled source still shuts down");
    a_source_fault: assert property ( // R03
        s_reg.asc[6:4] == 3'h4 |-> cond == s_reg.flt_s2)
        else $error("fault pin source decoded wrongly");
    a_source_both: assert property ( // R03
        s_reg.asc[6:4] == 3'h3 |-> cond == (cmp_eff[0] | c2_sel))
        else $error("either comparator source decoded wrongly");
    a_third_swap: assert property ( // R07
        s_reg.asc[6:4] == 3'h2
        |-> cond == (THIRD_MODULE ? cmp_eff[2] : cmp_eff[1]))
        else $error("second comparator source picked wrongly");
    // The pins are registered, so pin checks look one edge on.
    a_pin_shut_high: assert property ( // R04
        mode_ok && s_reg.steer_act[2] && s_reg.shut_out
        && s_reg.asc[3:2] == 2'h1 |=> pin_oe[2] && pin_out[2])
        else $error("pin c not driven high in shutdown");
    a_pin_shut_low_d: assert property ( // R05
        mode_ok && s_reg.steer_act[3] && s_reg.shut_out
        && s_reg.asc[1:0] == 2'h0 |=> pin_oe[3] && !pin_out[3])
        else $error("pin d not driven low in shutdown");
    a_cmp_direct: assert property ( // R06
        !comparator_sync_enable[0] |-> cmp_eff[0] == s_reg.cmp_s2[0])
        else $error("unsynchronised comparator delayed");
    a_restart_event: assert property ( // R08
        $fell(s_reg.asc[ASC_FLAG]) && $past(s_reg.pwc[PWC_RSEN])
        && !$past(wr_asc) |-> s_reg.ists[IRQ_RESTART])
        else $error("automatic restart not recorded");
    a_fall_at_once: assert property (!pwm_raw |=> !s_reg.wave_d) // R10
        else $error("inactive edge was delayed");
    a_delay_forced: assert property ( // R11
        clock_fallback_active |=> s_reg.pwc[6:0] == 7'h00)
        else $error("delay count not held at zero");
    a_steer_at_once: assert property ( // R12
        !s_reg.psc[PSC_SYNC] |=> s_reg.steer_act == $past(s_reg.psc[3:0]))
        else $error("unsynchronised steering update late");
    a_port_unsteered: assert property ( // R13
        !s_reg.steer_act[2] |=> pin_oe[2] == $past(port_oe[2])
        && pin_out[2] == $past(port_out[2]))
        else $error("unsteered pin c left port control");
    a_steer_drive: assert property ( // R13
        mode_ok && s_reg.steer_act[3] && !s_reg.shut_out
        |=> pin_oe[3] && pin_out[3] == $past(s_reg.wave_d ^ s_reg.mode[0]))
        else $error("steered pin d not carrying the waveform");
    a_mode_gate: assert property ( // R14
        !mode_ok |=> pin_oe == $past(port_oe) && pin_out == $past(port_out))
        else $error("steering active outside single-output mode");
    a_pol_ac: assert property ( // R15
        mode_ok && s_reg.steer_act[0] && !s_reg.shut_out
        |=> pin_out[0] == $past(s_reg.wave_d ^ s_reg.mode[1]))
        else $error("pin a polarity wrong");
    a_resume_tick: assert property ( // R16
        s_reg.shut_out && !flag_new && ptick |=> !s_reg.shut_out)
        else $error("outputs did not resume at period start");
endmodule
`default_nettype wire

// ===== hdl/epw_pkg.sv
// Constants for the enhanced PWM shutdown and steering block.
// Assumes an APB slave at 25 MHz with one aligned 32-bit word per register.
//
// Summary of operation
// R01: Fifth module timer field picks period timer two, four or six; 11 reserved.
// R02: Shutdown event sets status flag and forces all outputs to shutdown state; the core does so only for steered pins in single-output PWM mode.
// R03: Three-bit source select decodes comparators and low fault pin as shown.
// R04: Pins a and c shut down tri-stated, driven high or low.
// R05: Pins b and d shut down tri-stated, driven high or low.
// R06: Synchronised comparators cause shutdown only after the sixteen-bit timer tick.
// R07: In the third module, comparator three replaces comparator two.
// R08: With auto restart set, the flag clears itself once the cause is gone.
// R09: With auto restart clear, software clears the flag; outputs stay shut.
// R10: Delay count postpones each active-going edge by that many cycles.
// R11: Delay count is zero while the clock fallback condition holds.
// R12: Steering changes apply at next period, or next cycle when sync clear.
// R13: Each steering enable routes the waveform with polarity, else port control.
// R14: Steering works only in PWM mode with single output configuration.
// R15: Low two mode bits set a/c and b/d polarity.
// R16: Outputs stay shut until a period start after the flag clears.
package epw_pkg;
    // ************************************************************
    // Register byte offsets.
    // ************************************************************
    localparam logic [7:0] OFS_TSEL = 8'h00;
    localparam logic [7:0] OFS_ASC = 8'h04;
    localparam logic [7:0] OFS_PWC = 8'h08;
    localparam logic [7:0] OFS_PSC = 8'h0C;
    localparam logic [7:0] OFS_MODE = 8'h10;
    localparam logic [7:0] OFS_ISTS = 8'h14;
    localparam logic [7:0] OFS_IMSK = 8'h18;
    // ************************************************************
    // Reset values and field positions.
    // ************************************************************
    localparam logic [7:0] ASC_RST = 8'h00;
    localparam logic [7:0] PWC_RST = 8'h00;
    localparam logic [4:0] PSC_RST = 5'h01;
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam int ASC_FLAG = 7;
    localparam int PWC_RSEN = 7;
    localparam int PSC_SYNC = 4;
    localparam int IRQ_SHUT = 0;
    localparam int IRQ_RESTART = 1;
    localparam logic [1:0] TSEL_TWO = 2'h0;
    localparam logic [1:0] TSEL_FOUR = 2'h1;
    localparam logic [1:0] TSEL_SIX = 2'h2;
    localparam logic [1:0] MODE_PWM = 2'h3;
    localparam logic [1:0] CFG_SINGLE = 2'h0;
endpackage

// ===== bench/epw_partner.sv
// Far-side model: fault pin and comparator sources plus the bridge pins.
// Assumes the bench commands the sources; every bridge pin has a pull-down.
`timescale 1ns/1ps
`default_nettype none
module epw_partner (
    input wire logic clk,
    input wire logic fault_cmd,
    input wire logic [2:0] comp_cmd,
    input wire logic [3:0] pin_out,
    input wire logic [3:0] pin_oe,
    output logic fault_input_pin_n,
    output logic [2:0] comp,
    output logic [3:0] pin_level
);
    always_ff @(posedge clk) begin
        fault_input_pin_n <= !fault_cmd;
        comp <= comp_cmd;
    end
    // released pins pulled
    // A released pin reads low, never its last driven value.
    assign pin_level = pin_out & pin_oe;
endmodule
`default_nettype wire

// ===== bench/enhanced_pwm_shutdown_steering_tb_top.sv
// Self-checking bench for the enhanced PWM shutdown and steering core.
// Assumes epw_pkg, epw_core and epw_partner are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module enhanced_pwm_shutdown_steering_tb_top;
    import epw_pkg::*;
    // ****************
    // Signals
    // ****************
    logic clk = 1'h0, reset_n = 1'h0, psel = 1'h0, penable = 1'h0;
    logic pwrite = 1'h0, pwm_raw = 1'h0, t2 = 1'h0, t1t = 1'h0;
    logic t4 = 1'h0, t6 = 1'h0;
    logic fault_cmd = 1'h0, fb = 1'h0, pready, pslverr, irq, fault_n, err;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, q;
    logic [2:0] comp_cmd = 3'h0, csync = 3'h0, comp;
    logic [3:0] port_out = 4'h0, port_oe = 4'h0, pin_out, pin_oe, lvl;
    int n_errors = 0, n_compared = 0;
    always #20 clk = ~clk;
    epw_core dut (.clk(clk), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pwm_raw(pwm_raw), .period_tick_two(t2), .period_tick_four(t4),
        .period_tick_six(t6), .sixteen_bit_timer_tick(t1t),
        .fault_input_pin_n(fault_n), .comparator_one(comp[0]),
        .comparator_two(comp[1]), .comparator_three(comp[2]),
        .comparator_sync_enable(csync), .clock_fallback_active(fb),
        .port_out(port_out), .port_oe(port_oe), .pin_out(pin_out),
        .pin_oe(pin_oe), .irq(irq));
    epw_partner far (.clk(clk), .fault_cmd(fault_cmd), .comp_cmd(comp_cmd),
        .pin_out(pin_out), .pin_oe(pin_oe), .fault_input_pin_n(fault_n),
        .comp(comp), .pin_level(lvl));
    // ****************
    // Tasks
    // ****************
    task automatic end_of_test;
        $display("errors %0d, compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask
    // The idle edge at the end keeps back-to-back calls off one time step.
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        k = 0;
        psel <= 1'h1;
        pwrite <= w;
        paddr <= {24'h0, a};
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'h1 && k < 20);
        q = prdata;
        err = pslverr;
        if (k == 20) begin
            n_errors++;
            end_of_test;
        end
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'h1, a, d);
    endtask
    task automatic rd(input logic [7:0] a);
        apb(1'h0, a, 32'h0);
    endtask
    task automatic waitp(input logic [3:0] oe, input logic [3:0] lv);
        int k;
        k = 0;
        while ({pin_oe, lvl} !== {oe, lv} && k < 40) begin
            @(posedge clk);
            k++;
        end
        limit({pin_oe, lvl} === {oe, lv});
        chk("pins", {24'h0, oe, lv}, {24'h0, pin_oe, lvl});
    endtask
    // A wait that runs out of cycles ends the run as a failure.
    task automatic limit(input logic ok);
        if (ok !== 1'h1) begin
            n_errors++;
            end_of_test;
        end
    endtask
    task automatic tick_on(input logic [1:0] w);
        t2 <= (w == 2'h0);
        t4 <= (w == 2'h1);
        t6 <= (w == 2'h2);
        @(posedge clk);
        t2 <= 1'h0;
        t4 <= 1'h0;
        t6 <= 1'h0;
        repeat (3) @(posedge clk);
    endtask
    task automatic tick;
        tick_on(2'h0);
    endtask
    // ****************
    // Scenarios
    // ****************
    task automatic s_regs;
        rd(OFS_PSC);
        chk("steer reset", 32'h1, q);
        rd(OFS_ASC);
        chk("shutdown reset", 32'h0, q);
        wr(OFS_TSEL, 32'hFE);
        rd(OFS_TSEL);
        chk("timer field", 32'h2, q);
        wr(OFS_TSEL, 32'h0);
        rd(8'h1C);
        chk("unmapped", 32'h1, {31'h0, err});
    endtask
    task automatic s_src;
        logic [2:0] s;
        for (int i = 0; i < 24; i++) begin
            s = 3'(i / 3);
            wr(OFS_ASC, {24'h0, 1'h0, s, 4'h0});
            fault_cmd <= (i % 3 == 0);
            comp_cmd <= {1'h0, i % 3 == 2, i % 3 == 1};
            repeat (6) @(posedge clk);
            rd(OFS_ASC);
            chk("flag", {31'h0, s[(i % 3 + 2) % 3]}, {31'h0, q[7]});
            fault_cmd <= 1'h0;
            comp_cmd <= 3'h0;
            repeat (6) @(posedge clk);
            wr(OFS_ASC, 32'h0);
            tick;
        end
        wr(OFS_ASC, 32'h20);
        comp_cmd <= 3'h4;
        repeat (6) @(posedge clk);
        rd(OFS_ASC);
        chk("third comparator", 32'h0, {31'h0, q[7]});
        comp_cmd <= 3'h0;
    endtask
    task automatic s_states;
        logic [1:0] ac, bd;
        logic [3:0] oe, lv;
        wr(OFS_MODE, 32'hC);
        wr(OFS_PSC, 32'hF);
        wr(OFS_IMSK, 32'h1);
        for (int st = 0; st < 3; st++) begin
            ac = 2'(st);
            bd = 2'(2 - st);
            oe = {~bd[1], ~ac[1], ~bd[1], ~ac[1]};
            lv = {bd == 2'h1, ac == 2'h1, bd == 2'h1, ac == 2'h1};
            wr(OFS_ASC, {24'h0, 4'h4, ac, bd});
            fault_cmd <= 1'h1;
            waitp(oe, lv);
            repeat (2) @(posedge clk);
            chk("irq", 32'h1, {31'h0, irq});
            fault_cmd <= 1'h0;
            repeat (8) @(posedge clk);
            tick;
            chk("held", {24'h0, oe, lv}, {24'h0, pin_oe, lvl});
            wr(OFS_ASC, {24'h0, 4'h4, ac, bd});
            wr(OFS_ISTS, 32'h1);
            chk("early", {24'h0, oe, lv}, {24'h0, pin_oe, lvl});
            tick;
            chk("resumed", 32'hF0, {24'h0, pin_oe, lvl});
            chk("irq clear", 32'h0, {31'h0, irq});
        end
    endtask
    task automatic s_restart;
        wr(OFS_PWC, 32'h80);
        wr(OFS_ASC, 32'h10);
        comp_cmd <= 3'h1;
        repeat (6) @(posedge clk);
        rd(OFS_ASC);
        chk("flag set", 32'h1, {31'h0, q[7]});
        comp_cmd <= 3'h0;
        repeat (6) @(posedge clk);
        rd(OFS_ASC);
        chk("auto clear", 32'h0, {31'h0, q[7]});
        rd(OFS_ISTS);
        chk("restart event", 32'h1, {31'h0, q[1]});
        csync <= 3'h1;
        comp_cmd <= 3'h1;
        repeat (6) @(posedge clk);
        rd(OFS_ASC);
        chk("sync wait", 32'h0, {31'h0, q[7]});
        t1t <= 1'h1;
        @(posedge clk);
        t1t <= 1'h0;
        repeat (4) @(posedge clk);
        rd(OFS_ASC);
        chk("sync shut", 32'h1, {31'h0, q[7]});
        comp_cmd <= 3'h0;
        csync <= 3'h0;
        wr(OFS_PWC, 32'h0);
        wr(OFS_ASC, 32'h0);
        tick;
    endtask
    task automatic s_dead;
        int k;
        wr(OFS_PSC, 32'h1);
        wr(OFS_PWC, 32'h5);
        k = 0;
        pwm_raw <= 1'h1;
        do begin
            @(posedge clk);
            k++;
        end while (pin_out[0] !== 1'h1 && k < 40);
        limit(pin_out[0] === 1'h1);
        chk("rise delay", 32'h8, 32'(k));
        k = 0;
        pwm_raw <= 1'h0;
        do begin
            @(posedge clk);
            k++;
        end while (pin_out[0] !== 1'h0 && k < 40);
        limit(pin_out[0] === 1'h0);
        chk("fall delay", 32'h3, 32'(k));
        fb <= 1'h1;
        rd(OFS_PWC);
        chk("delay forced", 32'h0, q);
    endtask
    task automatic s_steer;
        logic [1:0] p;
        wr(OFS_PSC, 32'hF);
        for (int m = 0; m < 4; m++) begin
            p = 2'(m);
            wr(OFS_MODE, {24'h0, 6'h3, p});
            repeat (3) @(posedge clk);
            chk("polarity", {24'h0, 4'hF, p[0], p[1], p[0], p[1]},
                {24'h0, pin_oe, lvl});
        end
        port_out <= 4'hA;
        port_oe <= 4'h5;
        pwm_raw <= 1'h1;
        wr(OFS_MODE, 32'hC);
        wr(OFS_PSC, 32'h1);
        repeat (3) @(posedge clk);
        chk("steer a", 32'h5B, {24'h0, pin_oe, pin_out});
        wr(OFS_TSEL, 32'h1);
        wr(OFS_PSC, 32'h14);
        chk("sync hold", 32'h5B, {24'h0, pin_oe, pin_out});
        tick;
        chk("timer two ignored", 32'h5B, {24'h0, pin_oe, pin_out});
        tick_on(2'h1);
        chk("sync move", 32'h5E, {24'h0, pin_oe, pin_out});
        wr(OFS_TSEL, 32'h2);
        wr(OFS_PSC, 32'h11);
        tick_on(2'h1);
        chk("timer four ignored", 32'h5E, {24'h0, pin_oe, pin_out});
        tick_on(2'h2);
        chk("timer six", 32'h5B, {24'h0, pin_oe, pin_out});
        wr(OFS_MODE, 32'h4C);
        repeat (3) @(posedge clk);
        chk("not single", 32'h5A, {24'h0, pin_oe, pin_out});
    endtask
    // ****************
    // Run
    // ****************
    initial begin
        repeat (16) @(posedge clk);
        reset_n <= 1'h1;
        @(posedge clk);
        s_regs;
        s_src;
        s_states;
        s_restart;
        s_dead;
        s_steer;
        end_of_test;
    end
    initial begin
        repeat (100000) @(posedge clk);
        n_errors++;
        end_of_test;
    end
endmodule
`default_nettype wire
